/* File: bcs_bridge_regs.sv */
// bridge control and status register slice
`timescale 1ns/100ps
`default_nettype none
`include "bcs_params.svh"
module bcs_bridge_regs #(
    parameter int SYNC_STAGES = 3
) (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output var  logic [7:0] reg_rdata,
    input  wire logic       strap_pin_a,
    input  wire logic       input_supply_pin,
    input  wire logic       ext_osc_tick,
    input  wire logic       rx_irq,
    input  wire logic       cipher_irq,
    input  wire logic       cfg_done_in,
    input  wire logic       init_done_in,
    input  wire logic       config_checksum_in,
    input  wire logic       remote_load_done,
    input  wire logic       reload_done,
    input  wire logic       reload_checksum_ok,
    input  wire logic       ind_rd_done,
    input  wire logic [15:0] ind_rd_data,
    input  wire logic       ddc_req,
    output var  logic       ddc_grant,
    output var  logic       reload_start,
    output var  logic       wipe_start,
    output var  logic       cec_clk
);
    logic [7:0]  indirect_data_byte2;
    logic [7:0]  indirect_data_byte3;
    logic        cec_timebase_source;
    logic        cec_timebase_enable;
    logic        display_id_sram_wipe;
    logic        display_id_reload;
    logic        display_id_ddc_block;
    logic        strap_taken;
    logic [SYNC_STAGES-1:0] sup_sync;
    logic        input_supply_present;
    logic        cfg_seen;
    logic        init_seen;
    logic        remote_display_id_loaded;
    logic        config_checksum_ok;
    logic        display_id_checksum_ok;
    logic [7:0]  bridge_status;
    logic [7:0]  bridge_control;
    bcs_pkg::bcs_reload_t rl_state;
    bcs_tb_if tbi ();

    // the agree filter needs a first stage plus two comparing stages
    if (SYNC_STAGES < 3) begin : g_sync_depth_check
        $error("SYNC_STAGES below 3 is not supported");
    end

    assign tbi.enable = cec_timebase_enable;
    assign tbi.source = cec_timebase_source;
    bcs_cec_timebase u_tb (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .ext_osc_tick (ext_osc_tick),
        .tb           (tbi)
    );
    always_ff @(posedge mclk) begin
        cec_clk <= tbi.tick;
    end

    // strap captured on first clock after reset release, not under reset
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            strap_taken          <= 1'b0;
            display_id_ddc_block <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken          <= 1'b1;
            display_id_ddc_block <= strap_pin_a;
        end
    end

    // supply pin synchroniser: change accepted when the last two stages agree
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sup_sync             <= '0;
            input_supply_present <= 1'b0;
        end else begin
            sup_sync <= {sup_sync[SYNC_STAGES-2:0], input_supply_pin};
            if (sup_sync[SYNC_STAGES-2] == sup_sync[SYNC_STAGES-1])
                input_supply_present <= sup_sync[SYNC_STAGES-1];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            indirect_data_byte2 <= `BCS_RST_DATA;
            indirect_data_byte3 <= `BCS_RST_DATA;
        end else if (ind_rd_done) begin
            // completing read wins over a host write in the same cycle
            indirect_data_byte2 <= ind_rd_data[7:0];
            indirect_data_byte3 <= ind_rd_data[15:8];
        end else if (reg_wr) begin
            if (reg_addr == `BCS_OFF_DATA2)
                indirect_data_byte2 <= reg_wdata;
            else if (reg_addr == `BCS_OFF_DATA3)
                indirect_data_byte3 <= reg_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cec_timebase_source <= 1'b0;
            cec_timebase_enable <= 1'b0;
        end else if (reg_wr && reg_addr == `BCS_OFF_CTL) begin
            cec_timebase_source <= reg_wdata[`BCS_CTL_SRC];
            cec_timebase_enable <= reg_wdata[`BCS_CTL_EN];
        end
    end

    // reload sequencer; writes to reload bits ignored while busy
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rl_state             <= bcs_pkg::BCS_IDLE;
            display_id_reload    <= 1'b0;
            display_id_sram_wipe <= 1'b0;
            reload_start         <= 1'b0;
            wipe_start           <= 1'b0;
        end else begin
            reload_start <= 1'b0;
            wipe_start   <= 1'b0;
            case (rl_state)
                bcs_pkg::BCS_IDLE: begin
                    if (reg_wr && reg_addr == `BCS_OFF_CTL && reg_wdata[`BCS_CTL_RELOAD]) begin
                        display_id_reload    <= 1'b1;
                        display_id_sram_wipe <= reg_wdata[`BCS_CTL_WIPE];
                        wipe_start           <= reg_wdata[`BCS_CTL_WIPE];
                        reload_start         <= 1'b1;
                        rl_state             <= bcs_pkg::BCS_BUSY;
                    end
                end
                bcs_pkg::BCS_BUSY: begin
                    if (reload_done)
                        rl_state <= bcs_pkg::BCS_DONE;
                end
                bcs_pkg::BCS_DONE: begin
                    display_id_reload    <= 1'b0;
                    display_id_sram_wipe <= 1'b0;
                    rl_state             <= bcs_pkg::BCS_IDLE;
                end
                default: rl_state <= bcs_pkg::BCS_IDLE;
            endcase
        end
    end

    // status flags follow device events; host writes never touch them
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_seen                 <= 1'b0;
            init_seen                <= 1'b0;
            remote_display_id_loaded <= 1'b0;
            config_checksum_ok       <= 1'b1;
            display_id_checksum_ok   <= 1'b1;
        end else begin
            if (cfg_done_in)
                cfg_seen <= 1'b1;
            if (init_done_in && (cfg_seen || cfg_done_in))
                init_seen <= 1'b1;
            if (remote_load_done)
                remote_display_id_loaded <= 1'b1;
            if (cfg_done_in)
                config_checksum_ok <= config_checksum_in;
            if (reload_done || remote_load_done)
                display_id_checksum_ok <= reload_checksum_ok;
        end
    end

    // reserved control bits read back as zero
    always_comb begin
        bridge_control                  = 8'h00;
        bridge_control[`BCS_CTL_SRC]    = cec_timebase_source;
        bridge_control[`BCS_CTL_EN]     = cec_timebase_enable;
        bridge_control[`BCS_CTL_WIPE]   = display_id_sram_wipe;
        bridge_control[`BCS_CTL_RELOAD] = display_id_reload;
        bridge_control[`BCS_CTL_BLOCK]  = display_id_ddc_block;
    end

    always_comb begin
        bridge_status = 8'h00;
        bridge_status[`BCS_STS_SUPPLY]     = input_supply_present;
        bridge_status[`BCS_STS_RX_IRQ]     = rx_irq;
        bridge_status[`BCS_STS_CIPHER_IRQ] = cipher_irq;
        bridge_status[`BCS_STS_INIT]       = init_seen;
        bridge_status[`BCS_STS_REMOTE]     = remote_display_id_loaded;
        bridge_status[`BCS_STS_CFG]        = cfg_seen;
        bridge_status[`BCS_STS_CFG_CK]     = config_checksum_ok;
        bridge_status[`BCS_STS_ID_CK]      = display_id_checksum_ok;
    end

    // read data registered; status offset has no write path
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `BCS_OFF_DATA2)
                reg_rdata <= indirect_data_byte2;
            else if (reg_addr == `BCS_OFF_DATA3)
                reg_rdata <= indirect_data_byte3;
            else if (reg_addr == `BCS_OFF_CTL)
                reg_rdata <= bridge_control;
            else if (reg_addr == `BCS_OFF_STS)
                reg_rdata <= bridge_status;
            else
                reg_rdata <= 8'h00;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst)
            ddc_grant <= 1'b0;
        else
            ddc_grant <= ddc_req && strap_taken && !display_id_ddc_block;
    end
endmodule
`default_nettype wire

/* File: bcs_params.svh */
// register offsets, reset values, field positions and clock rates
`ifndef BCS_PARAMS_SVH
`define BCS_PARAMS_SVH
`define BCS_OFF_DATA2        8'h4d
`define BCS_OFF_DATA3        8'h4e
`define BCS_OFF_CTL          8'h4f
`define BCS_OFF_STS          8'h50
`define BCS_RST_DATA         8'h00
`define BCS_RST_STS          8'h03
`define BCS_CTL_SRC          4
`define BCS_CTL_EN           3
`define BCS_CTL_WIPE         2
`define BCS_CTL_RELOAD       1
`define BCS_CTL_BLOCK        0
`define BCS_STS_SUPPLY       7
`define BCS_STS_RX_IRQ       6
`define BCS_STS_CIPHER_IRQ   5
`define BCS_STS_INIT         4
`define BCS_STS_REMOTE       3
`define BCS_STS_CFG          2
`define BCS_STS_CFG_CK       1
`define BCS_STS_ID_CK        0
`define BCS_CEC_HZ_X1000     32768000
`define BCS_INT_REF_HZ       20000000
`define BCS_EXT_REF_HZ       25000000
`endif

/* File: bcs_pkg.sv */
// types shared by the bridge control/status block
`default_nettype none
package bcs_pkg;
    typedef enum logic [2:0] {
        BCS_IDLE  = 3'b001,
        BCS_BUSY  = 3'b010,
        BCS_DONE  = 3'b100
    } bcs_reload_t;
endpackage
`default_nettype wire

/* File: bcs_tb_if.sv */
// carrier between the control bank and the cec timebase generator
`timescale 1ns/100ps
`default_nettype none
interface bcs_tb_if;
    logic enable;
    logic source;
    logic tick;
    modport ctl (output enable, output source, input tick);
    modport gen (input enable, input source, output tick);
endinterface
`default_nettype wire

/* File: bcs_cec_timebase.sv */
// fractional 32.768 kHz cec timebase generator
`timescale 1ns/100ps
`default_nettype none
`include "bcs_params.svh"
module bcs_cec_timebase (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ext_osc_tick,
    bcs_tb_if.gen    tb
);
    // phase accumulator: add twice the cec rate, wrap at reference rate, scaled by 1000
    // each wrap is one half period, so the toggle output runs at the cec rate
    localparam logic [35:0] INC      = 36'(64'(`BCS_CEC_HZ_X1000) * 2);
    localparam logic [35:0] MOD_INT  = 36'(64'(`BCS_INT_REF_HZ) * 1000);
    localparam logic [35:0] MOD_EXT  = 36'(64'(`BCS_EXT_REF_HZ) * 1000);
    logic [35:0] acc;
    logic        out;
    logic        step;
    logic [35:0] modv;
    assign step = tb.source ? ext_osc_tick : 1'b1;
    assign modv = tb.source ? MOD_EXT : MOD_INT;
    always_ff @(posedge mclk) begin
        if (sys_rst || !tb.enable) begin
            acc <= 36'h0;
            out <= 1'b0;
        end else if (step) begin
            if (acc + INC >= modv) begin
                acc <= acc + INC - modv;
                out <= ~out;
            end else begin
                acc <= acc + INC;
            end
        end
    end
    // square wave level, one full period per two wraps
    assign tb.tick = out;
endmodule
`default_nettype wire

/* File: bcs_bridge_regs_assertions.sv */
// concurrent checks on the bridge control and status slice ports
`timescale 1ns/100ps
`default_nettype none
`include "bcs_params.svh"
module bcs_bridge_regs_assertions (
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       strap_pin_a,
    input wire logic       rx_irq,
    input wire logic       cipher_irq,
    input wire logic       ddc_req,
    input wire logic       ddc_grant,
    input wire logic       reload_start,
    input wire logic       wipe_start
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire sts_rd = reg_rd && reg_addr == `BCS_OFF_STS;
    // strap only moves inside reset, so the first edge after release is skipped
    a_grant_open: assert property (!$past(sys_rst) && ddc_req && !strap_pin_a |=> ddc_grant)
        else $error("ddc grant missing");
    a_grant_shut: assert property (!$past(sys_rst) && strap_pin_a |=> !ddc_grant)
        else $error("ddc grant while blocked");
    a_reload_cause: assert property (reload_start |->
        $past(reg_wr && reg_addr == `BCS_OFF_CTL && reg_wdata[`BCS_CTL_RELOAD]))
        else $error("reload pulse without write");
    a_reload_pulse: assert property (reload_start |=> !reload_start)
        else $error("reload pulse too long");
    a_wipe_pair: assert property (wipe_start |-> reload_start &&
        $past(reg_wdata[`BCS_CTL_WIPE] && reg_wdata[`BCS_CTL_RELOAD]))
        else $error("wipe without reload");
    a_irq_live: assert property (sts_rd |=> reg_rdata[6:5] == $past({rx_irq, cipher_irq}))
        else $error("irq status bits wrong");
    a_init_order: assert property (sts_rd |=> !(reg_rdata[`BCS_STS_INIT] && !reg_rdata[`BCS_STS_CFG]))
        else $error("init done before cfg done");
    a_unmapped_zero: assert property (reg_rd && (reg_addr < `BCS_OFF_DATA2 || reg_addr > `BCS_OFF_STS)
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    c_wipe: cover property (wipe_start);
    c_init: cover property (sts_rd ##1 reg_rdata[`BCS_STS_INIT]);
    c_grant: cover property (ddc_grant);
endmodule
`default_nettype wire

/* File: bcs_host_model.sv */
// host controller model on the register strobe bus
`timescale 1ns/100ps
`default_nettype none
module bcs_host_model (
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        // released bus shows garbage, not the last value
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the bridge control and status slice
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        strap_pin_a = 1'b0;
    logic        input_supply_pin = 1'b0;
    logic        ext_osc_tick = 1'b0;
    logic        rx_irq = 1'b0;
    logic        cipher_irq = 1'b0;
    logic        config_checksum_in = 1'b0;
    logic        reload_checksum_ok = 1'b0;
    logic        ddc_req = 1'b1;
    logic [4:0]  ev = 5'h00;
    logic [15:0] ind_rd_data = 16'h0000;
    logic        reg_wr, reg_rd, ddc_grant, reload_start, wipe_start, cec_clk;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    int          mismatches = 0;
    int          comparisons = 0;
    int          k;
    always #25 mclk = ~mclk;
    bcs_host_model host_i (.mclk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    bcs_bridge_regs bcs_bridge_regs_i (.mclk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .strap_pin_a, .input_supply_pin, .ext_osc_tick, .rx_irq, .cipher_irq, .cfg_done_in(ev[0]),
        .init_done_in(ev[1]), .config_checksum_in, .remote_load_done(ev[2]), .reload_done(ev[3]),
        .reload_checksum_ok, .ind_rd_done(ev[4]), .ind_rd_data, .ddc_req, .ddc_grant, .reload_start,
        .wipe_start, .cec_clk);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_i.rd(a, d);
        chk(d, exp);
    endtask
    task automatic rst(input logic s);
        @(posedge mclk);
        sys_rst <= 1'b1;
        strap_pin_a <= s;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic pulse(input int i);
        @(posedge mclk);
        ev[i] <= 1'b1;
        @(posedge mclk);
        ev[i] <= 1'b0;
    endtask
    // bounded count of cec clock rising edges
    task automatic edges(input int n, output int c);
        logic p;
        p = cec_clk;
        c = 0;
        repeat (n) begin
            @(posedge mclk);
            #1;
            if (cec_clk && !p) c++;
            p = cec_clk;
        end
    endtask
    task automatic t_reset;
        rdc(8'h4d, 8'h00);
        rdc(8'h4e, 8'h00);
        rdc(8'h50, 8'h03);
        rdc(8'h4f, 8'h00);
        rdc(8'h40, 8'h00);
        chk({7'h0, ddc_grant}, 8'h01);
        ddc_req <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk({7'h0, ddc_grant}, 8'h00);
        ddc_req <= 1'b1;
    endtask
    task automatic t_data;
        host_i.wr(8'h4d, 8'ha5);
        host_i.wr(8'h4e, 8'h5a);
        rdc(8'h4d, 8'ha5);
        rdc(8'h4e, 8'h5a);
        ind_rd_data <= 16'hc33c;
        fork
            host_i.wr(8'h4d, 8'hff);
            pulse(4);
        join
        rdc(8'h4d, 8'h3c);
        rdc(8'h4e, 8'hc3);
    endtask
    task automatic t_status;
        pulse(1);
        rdc(8'h50, 8'h03);
        pulse(0);
        rdc(8'h50, 8'h05);
        pulse(1);
        rdc(8'h50, 8'h15);
        pulse(2);
        rdc(8'h50, 8'h1c);
        input_supply_pin <= 1'b1;
        rx_irq <= 1'b1;
        repeat (5) @(posedge mclk);
        rdc(8'h50, 8'hdc);
        cipher_irq <= 1'b1;
        rdc(8'h50, 8'hfc);
        host_i.wr(8'h50, 8'h00);
        rdc(8'h50, 8'hfc);
    endtask
    task automatic t_reload;
        host_i.wr(8'h4f, 8'he6);
        #1;
        chk({6'h0, reload_start, wipe_start}, 8'h03);
        rdc(8'h4f, 8'h06);
        host_i.wr(8'h4f, 8'h02);
        #1;
        chk({6'h0, reload_start, wipe_start}, 8'h00);
        rdc(8'h4f, 8'h06);
        reload_checksum_ok <= 1'b1;
        pulse(3);
        repeat (2) @(posedge mclk);
        rdc(8'h4f, 8'h00);
        rdc(8'h50, 8'hfd);
        host_i.wr(8'h4f, 8'h04);
        #1;
        chk({6'h0, reload_start, wipe_start}, 8'h00);
        rdc(8'h4f, 8'h00);
    endtask
    task automatic t_cec;
        host_i.wr(8'h4f, 8'h08);
        edges(12200, k);
        chk(8'(k >= 19 && k <= 21), 8'h01);
        ext_osc_tick <= 1'b1;
        host_i.wr(8'h4f, 8'h18);
        edges(12200, k);
        chk(8'(k >= 15 && k <= 17), 8'h01);
        host_i.wr(8'h4f, 8'h00);
        repeat (2) @(posedge mclk);
        edges(2000, k);
        chk(8'(k), 8'h00);
        chk({7'h0, cec_clk}, 8'h00);
    endtask
    task automatic t_strap;
        rst(1'b1);
        rdc(8'h4f, 8'h01);
        chk({7'h0, ddc_grant}, 8'h00);
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        rst(1'b0);
        t_reset();
        t_data();
        t_status();
        t_reload();
        t_cec();
        t_strap();
        tally_and_finish();
    end
endmodule
bind bcs_bridge_regs bcs_bridge_regs_assertions chk_i (.mclk, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .strap_pin_a, .rx_irq, .cipher_irq, .ddc_req, .ddc_grant, .reload_start,
    .wipe_start);
`default_nettype wire
